// *** common/lcd_drive_pkg.sv ***
// Shared constants for the segment display waveform and sleep block
package lcd_drive_pkg;

	// Display clock source selection codes
	localparam logic [1:0] SRC_SYS         = 2'h0;
	localparam logic [1:0] SRC_TIMER       = 2'h1;
	localparam logic [1:0] SRC_LF_A        = 2'h2;
	localparam logic [1:0] SRC_LF_B        = 2'h3;

	// Source division ratios
	localparam int         SYS_DIV         = 8192;
	localparam int         OSC_DIV         = 32;

	// Drive level codes, index into the bias ladder (V0 lowest)
	localparam logic [1:0] LVL_V0          = 2'h0;
	localparam logic [1:0] LVL_V1          = 2'h1;
	localparam logic [1:0] LVL_V2          = 2'h2;
	localparam logic [1:0] LVL_V3          = 2'h3;

	// Position of the bits inside the display control register image
	localparam int         ERR_FLAG_POS    = 5;
	localparam int         SLEEP_BIT_POS   = 6;

	// Multiplex setting meaning static drive
	localparam logic [1:0] MUX_STATIC      = 2'h0;

	// Reset values
	localparam logic [1:0] RST_COM_IDX     = 2'h0;
	localparam logic       RST_PHASE       = 1'b0;
	localparam logic       RST_ERR_FLAG    = 1'b0;

endpackage : lcd_drive_pkg

// *** rtl/lcd_frame_waveform_sleep.sv ***
// Segment display common/segment waveform, frame event and sleep control
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] Drive waveforms keep zero average DC across every pixel.
// [RULE_02] Commons mark time slices, segments carry pixel data, two rms levels.
// [RULE_03] Dark pixels see the higher rms level, clear pixels the lower.
// [RULE_04] Type A inverts phase inside each common slice, balanced per frame.
// [RULE_05] Type B inverts phase at each frame boundary, balanced per frame pair.
// [RULE_06] With system clock source the display sleeps whenever the core sleeps.
// [RULE_07] A frame starts at the leading edge of the first common slice.
// [RULE_08] Frame event fires right after last pixel fetch, one slice before boundary.
// [RULE_09] Write window runs from the event to the next fetch; software writes then.
// [RULE_10] Software keeps type B multiplexed data unchanged across a frame pair.
// [RULE_11] Type B frame event only at the end of a complete phase pair.
// [RULE_12] A pixel write while writing is blocked sets the write error bit.
// [RULE_13] No frame event for type A nor for static type B.
// [RULE_14] Sleep enable set: display sleeps with core; clear: keeps running.
// [RULE_15] Sleeping display stops at once, all lines at minimum voltage.
// [RULE_16] Software enters sleep just after a frame boundary.
// [RULE_17] Sleep enable clear: display keeps showing current pixel data.
// [RULE_18] Running in sleep only from timer or low-frequency oscillator.
// [RULE_19] Pixel data cannot change while the core sleeps.
// [RULE_20] Source: system clock /8192, timer osc /32 or low-freq osc /32.
// [RULE_21] Write error stays set until software clears it.
module lcd_frame_waveform_sleep #(
	parameter int NUM_COM = 4,
	parameter int NUM_SEG = 24
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rstn_i,
	// Oscillator pins (asynchronous)
	input  wire logic                         timer_oscillator_i,
	input  wire logic                         low_freq_internal_osc_i,
	// Control bits
	input  wire logic                         drive_enable_i,
	input  wire logic                         wave_type_b_i,
	input  wire logic [1:0]                   common_count_select_i,
	input  wire logic [1:0]                   clk_src_sel_i,
	input  wire logic                         display_sleep_enable_i,
	input  wire logic                         core_sleep_i,
	// Pixel write port
	input  wire logic                         pix_wr_i,
	input  wire logic [1:0]                   pix_wr_row_i,
	input  wire logic [NUM_SEG-1:0]           pix_wr_data_i,
	input  wire logic                         write_error_clr_i,
	// Status
	output logic                              frame_irq_o,
	output logic                              write_window_o,
	output logic                              write_error_flag_o,
	output logic                              display_asleep_o,
	output logic [7:0]                        display_control_reg_o,
	// Panel drive level codes
	output logic [NUM_COM-1:0][1:0]           common_line_o,
	output logic [NUM_SEG-1:0][1:0]           segment_line_o
);

	// Sequencer and row decode only serve four commons
	if (NUM_COM != 4)
	begin : g_bad_com
		$error("lcd_frame_waveform_sleep: NUM_COM must be 4");
	end
	if (NUM_SEG < 1)
	begin : g_bad_seg
		$error("lcd_frame_waveform_sleep: NUM_SEG must be positive");
	end

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [1:0]                     tmr_sync;
		logic [1:0]                     lf_sync;
		logic                           tmr_prev;
		logic                           lf_prev;
		logic [1:0]                     com_idx;
		logic                           half;
		logic                           phase;
		logic                           win_open;
		logic                           irq;
		logic                           err;
		logic                           sleep_en;
		logic                           asleep;
		logic [NUM_COM-1:0][NUM_SEG-1:0] pix;
		logic [NUM_COM-1:0][1:0]         com_lvl;
		logic [NUM_SEG-1:0][1:0]         seg_lvl;
	} state_s;

	state_s q;
	state_s d;

	////////////////////////////////////////////////////////////////////////
	// Display clock sources

	logic tmr_edge;
	logic lf_edge;
	logic sys_tick;
	logic tmr_tick;
	logic lf_tick;
	logic src_sys;
	logic disp_tick;

	// Edges come from the second stage only
	assign tmr_edge = q.tmr_sync[1] & ~q.tmr_prev;
	assign lf_edge  = q.lf_sync[1] & ~q.lf_prev;
	assign src_sys  = (clk_src_sel_i == lcd_drive_pkg::SRC_SYS);

	// System oscillator halts with the core, so its divider halts too
	tick_divider #(.DIV(lcd_drive_pkg::SYS_DIV)) u_sys_div ( // RULE_20
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.en_i    (~core_sleep_i),
		.tick_o  (sys_tick)
	);

	tick_divider #(.DIV(lcd_drive_pkg::OSC_DIV)) u_tmr_div ( // RULE_20
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.en_i    (tmr_edge),
		.tick_o  (tmr_tick)
	);

	tick_divider #(.DIV(lcd_drive_pkg::OSC_DIV)) u_lf_div ( // RULE_20
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.en_i    (lf_edge),
		.tick_o  (lf_tick)
	);

	always_comb
	begin
		unique case (clk_src_sel_i)
			lcd_drive_pkg::SRC_SYS:   disp_tick = sys_tick;
			lcd_drive_pkg::SRC_TIMER: disp_tick = tmr_tick;
			lcd_drive_pkg::SRC_LF_A:  disp_tick = lf_tick;
			lcd_drive_pkg::SRC_LF_B:  disp_tick = lf_tick;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep, write gating and timing decode

	logic       go_sleep;
	logic       running;
	logic       bmux;
	logic       wr_ok;
	logic       pol;
	logic [1:0] last_idx;
	logic [1:0] next_idx;

	// System source cannot run in sleep whatever the enable bit says
	assign go_sleep = core_sleep_i
		& (display_sleep_enable_i | src_sys); // RULE_06 RULE_14 RULE_18
	assign running  = drive_enable_i & ~go_sleep; // RULE_17
	assign bmux     = wave_type_b_i
		& (common_count_select_i != lcd_drive_pkg::MUX_STATIC);
	assign last_idx = common_count_select_i;
	assign next_idx = (q.com_idx == last_idx) ? 2'h0 : q.com_idx + 2'h1;

	// Type B multiplexed data may only change inside the window while the drive is enabled
	assign wr_ok = ~core_sleep_i
		& (~drive_enable_i | ~bmux | q.win_open); // RULE_09 RULE_19

	// Type A flips inside the slice, type B once per frame
	assign pol = wave_type_b_i ? q.phase : q.half; // RULE_04 RULE_05

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		d          = q;
		d.irq      = 1'b0;
		d.tmr_sync = {q.tmr_sync[0], timer_oscillator_i};
		d.lf_sync  = {q.lf_sync[0], low_freq_internal_osc_i};
		d.tmr_prev = q.tmr_sync[1];
		d.lf_prev  = q.lf_sync[1];
		d.asleep   = go_sleep;
		d.sleep_en = display_sleep_enable_i; // RULE_14

		// Pixel writes
		if (pix_wr_i && wr_ok)
			d.pix[pix_wr_row_i] = pix_wr_data_i;
		if (write_error_clr_i)
			d.err = 1'b0;
		// A refused write in the clearing cycle still leaves the flag set
		if (pix_wr_i && !wr_ok)
			d.err = 1'b1; // RULE_12 RULE_21

		// Slice sequencer
		if (!running)
			d.win_open = 1'b0;
		else if (disp_tick)
		begin
			if (!wave_type_b_i)
			begin
				// Two halves per slice, opposite polarity
				d.half = ~q.half; // RULE_04
				if (q.half)
					d.com_idx = next_idx;
				d.win_open = 1'b0;
			end
			else
			begin
				d.half    = 1'b0;
				d.com_idx = next_idx;
				if (next_idx == 2'h0)
				begin
					d.phase    = ~q.phase; // RULE_05
					d.win_open = 1'b0; // RULE_09
				end
				// Last slice of the second frame: all data of the pair is fetched
				if (bmux && next_idx == last_idx && q.phase)
				begin
					d.irq      = 1'b1; // RULE_08 RULE_11 RULE_13
					d.win_open = 1'b1; // RULE_09
				end
			end
		end

		// Panel drive levels
		for (int c = 0; c < NUM_COM; c++)
		begin
			if (!running || c > int'(last_idx))
				d.com_lvl[c] = lcd_drive_pkg::LVL_V0; // RULE_15
			else if (last_idx == lcd_drive_pkg::MUX_STATIC)
				d.com_lvl[c] = pol ? lcd_drive_pkg::LVL_V0
					: lcd_drive_pkg::LVL_V3;
			else if (c == int'(q.com_idx))
				// Slice start of common 0 is the frame start
				d.com_lvl[c] = pol ? lcd_drive_pkg::LVL_V0
					: lcd_drive_pkg::LVL_V3; // RULE_02 RULE_07
			else
				d.com_lvl[c] = pol ? lcd_drive_pkg::LVL_V2
					: lcd_drive_pkg::LVL_V1;
		end
		for (int s = 0; s < NUM_SEG; s++)
		begin
			if (!running)
				d.seg_lvl[s] = lcd_drive_pkg::LVL_V0; // RULE_15
			else if (last_idx == lcd_drive_pkg::MUX_STATIC)
				// Dark sees full swing against the common, clear sees none
				d.seg_lvl[s] = (q.pix[0][s] ^ pol) ? lcd_drive_pkg::LVL_V0
					: lcd_drive_pkg::LVL_V3; // RULE_01 RULE_03
			else if (q.pix[q.com_idx][s])
				d.seg_lvl[s] = pol ? lcd_drive_pkg::LVL_V3
					: lcd_drive_pkg::LVL_V0; // RULE_01 RULE_03
			else
				d.seg_lvl[s] = pol ? lcd_drive_pkg::LVL_V1
					: lcd_drive_pkg::LVL_V2; // RULE_02
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q         <= '0;
			q.com_idx <= lcd_drive_pkg::RST_COM_IDX;
			q.phase   <= lcd_drive_pkg::RST_PHASE;
			q.err     <= lcd_drive_pkg::RST_ERR_FLAG;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign frame_irq_o        = q.irq;
	assign write_window_o     = q.win_open;
	assign write_error_flag_o = q.err;
	assign display_asleep_o   = q.asleep;
	assign common_line_o      = q.com_lvl;
	assign segment_line_o     = q.seg_lvl;

	always_comb
	begin
		display_control_reg_o = 8'h00;
		display_control_reg_o[lcd_drive_pkg::ERR_FLAG_POS]  = q.err; // RULE_12
		display_control_reg_o[lcd_drive_pkg::SLEEP_BIT_POS] =
			q.sleep_en; // RULE_14
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n);

	irq_typeb_only_a: assert property ( // RULE_13
		frame_irq_o |-> $past(bmux) && write_window_o
	) else $error("frame event outside multiplexed type B");

	irq_last_slice_a: assert property ( // RULE_11
		frame_irq_o |-> q.com_idx == $past(last_idx) && q.phase
	) else $error("frame event not at end of phase pair");

	err_set_a: assert property ( // RULE_12
		pix_wr_i && !wr_ok |=> write_error_flag_o
	) else $error("blocked write did not raise error");

	err_sticky_a: assert property ( // RULE_21
		write_error_flag_o && !write_error_clr_i |=> write_error_flag_o
	) else $error("error flag dropped without clear");

	sleep_min_level_a: assert property ( // RULE_15
		go_sleep |=> (common_line_o == '0) && (segment_line_o == '0)
	) else $error("sleeping display not at minimum level");

	sleep_freeze_a: assert property ( // RULE_19
		core_sleep_i |=> $stable(q.pix)
	) else $error("pixel data changed during sleep");

	typea_half_flip_a: assert property ( // RULE_04
		running && disp_tick && !wave_type_b_i && !q.half
		|=> q.half && q.com_idx == $past(q.com_idx)
	) else $error("type A slice did not invert in place");

	typeb_frame_flip_a: assert property ( // RULE_05
		running && disp_tick && wave_type_b_i && q.com_idx == last_idx
		|=> q.phase != $past(q.phase) && q.com_idx == 2'h0
	) else $error("type B phase not inverted at frame boundary");

	sys_sleep_a: assert property ( // RULE_06
		core_sleep_i && src_sys |=> display_asleep_o
	) else $error("system source display kept running in sleep");

	awake_run_a: assert property ( // RULE_17
		core_sleep_i && !display_sleep_enable_i && !src_sys
		|=> !display_asleep_o
	) else $error("display stopped with sleep enable clear");

	irq_seen_c: cover property (frame_irq_o ##1 write_window_o);
	err_seen_c: cover property (pix_wr_i && !wr_ok ##1 write_error_flag_o);
	asleep_seen_c: cover property (display_asleep_o ##1 !display_asleep_o);

endmodule : lcd_frame_waveform_sleep

// *** rtl/tick_divider.sv ***
// Enable-pulse divider: one output pulse for every DIV input pulses
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIV = 32
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Tick in and out
	input  wire logic en_i,
	output logic      tick_o
);

	localparam int CW = $clog2(DIV);

	// Refuse a ratio the counter cannot serve
	if (DIV < 2)
	begin : g_bad_div
		$error("tick_divider: DIV must be at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} div_s;

	div_s q;
	div_s d;

	always_comb
	begin
		d      = q;
		d.tick = 1'b0;
		if (en_i)
		begin
			if (q.cnt == CW'(DIV - 1))
			begin
				d.cnt  = '0;
				d.tick = 1'b1;
			end
			else
				d.cnt = q.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign tick_o = q.tick;

endmodule : tick_divider

// *** testbench/lcd_frame_waveform_sleep_tb.sv ***
// Self-checking bench for the display waveform, frame event and sleep block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s exp %0d got %0d", nm, e, g); end end
module lcd_frame_waveform_sleep_tb;
	logic             ref_clk_i, rstn_i, tmr_osc, lf_osc, drv_en, type_b;
	logic             slp_en, core_slp, pix_wr, wr_clr, clr_acc;
	logic             irq, win, err, asleep, err_m;
	logic [1:0]       mux, src, wr_row;
	logic [23:0]      wr_data;
	logic [7:0]       ctl;
	logic [3:0][1:0]  common_line;
	logic [23:0][1:0] segment_line;
	logic [23:0]      pix_m [4];
	logic [31:0]      rng;
	int               fails, check_count, irq_cnt, k, dcd, dcc, en_d, en_c;

	lcd_frame_waveform_sleep dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.timer_oscillator_i(tmr_osc), .low_freq_internal_osc_i(lf_osc),
		.drive_enable_i(drv_en), .wave_type_b_i(type_b),
		.common_count_select_i(mux), .clk_src_sel_i(src),
		.display_sleep_enable_i(slp_en), .core_sleep_i(core_slp),
		.pix_wr_i(pix_wr), .pix_wr_row_i(wr_row), .pix_wr_data_i(wr_data),
		.write_error_clr_i(wr_clr), .frame_irq_o(irq), .write_window_o(win),
		.write_error_flag_o(err), .display_asleep_o(asleep),
		.display_control_reg_o(ctl), .common_line_o(common_line),
		.segment_line_o(segment_line));
	lcd_panel_model panel (.clk_i(ref_clk_i), .clr_i(clr_acc), .com_i(common_line),
		.seg_i(segment_line), .dc_dark_o(dcd), .dc_clear_o(dcc), .en_dark_o(en_d),
		.en_clear_o(en_c));

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// Oscillators offset so their edges never meet a clock edge
	initial
	begin
		tmr_osc = 1'b0;
		lf_osc  = 1'b0;
		#1;
		fork
			forever #8 tmr_osc = ~tmr_osc;
			forever #12 lf_osc = ~lf_osc;
		join
	end

	always @(posedge ref_clk_i)
		irq_cnt <= clr_acc ? 0 : irq_cnt + int'(irq === 1'b1);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[23:0];
	endfunction : xs

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : cyc

	task automatic gap(output int n);
		logic [1:0] v;
		v = common_line[0];
		n = 0;
		while (n < 20000 && common_line[0] === v)
		begin
			cyc(1);
			n++;
		end
	endtask : gap

	task automatic do_reset();
		@(posedge ref_clk_i);
		rstn_i <= 1'b0;
		drv_en <= 1'b0;
		cyc(2);
		`CHK("reset_lines", 56'h0, {common_line, segment_line})
		`CHK("reset_flags", 3'h0, {irq, win, err})
		rstn_i <= 1'b1;
		cyc(3);
		err_m = 1'b0;
	endtask : do_reset

	task automatic wr(input logic [1:0] r, input logic [23:0] d,
		input logic c, input logic refuse);
		@(posedge ref_clk_i);
		pix_wr  <= 1'b1;
		wr_row  <= r;
		wr_data <= d;
		wr_clr  <= c;
		@(posedge ref_clk_i);
		pix_wr <= 1'b0;
		wr_clr <= 1'b0;
		if (!refuse)
			pix_m[r] = d;
		err_m = refuse | (err_m & ~c);
		@(posedge ref_clk_i);
		#1;
		`CHK("err_flag", err_m, err)
		`CHK("ctl_reg", {1'b0, slp_en, err_m, 5'h00}, ctl)
		// Leave on an edge so callers drive the next inputs there
		@(posedge ref_clk_i);
	endtask : wr

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rstn_i, drv_en, type_b, slp_en, core_slp} = '0;
		{pix_wr, wr_clr, clr_acc, err_m, mux, src, wr_row, wr_data} = '0;
		rng = 32'h47;
		// Window of 24 ticks holds whole balance periods of every mode
		for (int t = 0; t < 2; t++)
			for (int m = 0; m < 4; m++)
			begin
				do_reset();
				type_b <= t[0];
				mux    <= m[1:0];
				src    <= 2'h1;
				for (int r = 0; r < 4; r++)
					wr(r[1:0], r == 0 ? (xs() & 24'hFFFFFC) | 24'h1 : xs(),
						1'b0, 1'b0);
				drv_en <= 1'b1;
				cyc(200);
				clr_acc <= 1'b1;
				cyc(1);
				clr_acc <= 1'b0;
				cyc(3072);
				#1;
				`CHK("dc_dark", 0, dcd)
				`CHK("dc_clear", 0, dcc)
				`CHK("rms_order", pix_m[0][0] & ~pix_m[0][1], en_d > en_c)
				`CHK("irq_count", (t && m) ? 12 / (m + 1) : 0, irq_cnt)
			end
		$display("test waveform done");
		// Type B, four commons, still running
		for (k = 0; k < 2000 && irq !== 1'b1; k++)
			cyc(1);
		`CHK("window_open", 1'b1, win)
		for (k = 0; k < 400 && win !== 1'b0; k++)
			cyc(1);
		wr(2'h0, xs(), 1'b0, 1'b1);
		wr(2'h1, xs(), 1'b1, 1'b1);
		for (k = 0; k < 2000 && irq !== 1'b1; k++)
			cyc(1);
		wr(2'h2, xs(), 1'b0, 1'b0);
		wr(2'h3, xs(), 1'b1, 1'b0);
		$display("test write error done");
		for (int s = 0; s < 4; s++)
			for (int e = 0; e < 2; e++)
			begin
				// Sleep is entered just after a frame boundary
				src <= 2'h1;
				for (k = 0; k < 2000 && win !== 1'b1; k++)
					cyc(1);
				for (k = 0; k < 400 && win !== 1'b0; k++)
					cyc(1);
				`CHK("sleep_at_boundary", 1'b0, win)
				@(posedge ref_clk_i);
				src      <= s[1:0];
				slp_en   <= e[0];
				core_slp <= 1'b1;
				cyc(3);
				`CHK("asleep", e == 1 || s == 0, asleep)
				cyc(3);
				if (e == 1 || s == 0)
					`CHK("sleep_lines", 56'h0, {common_line, segment_line})
				else
				begin
					gap(k);
					`CHK("runs_in_sleep", 1'b1, k < 1000)
				end
				wr(2'h1, xs(), 1'b0, 1'b1);
				core_slp <= 1'b0;
				wr_clr   <= 1'b1;
				cyc(1);
				wr_clr <= 1'b0;
				err_m = 1'b0;
			end
		$display("test sleep done");
		do_reset();
		type_b <= 1'b1;
		mux    <= 2'h0;
		drv_en <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			src <= s[1:0];
			gap(k);
			gap(k);
			gap(k);
			`CHK("tick_period", s == 0 ? 8192 : s == 1 ? 128 : 192, k)
		end
		$display("test clock source done");
		complete_run();
	end

	// Whole run needs about 55k cycles
	initial
	begin
		#400000;
		fails++;
		$display("[ERR] watchdog exp done got hang");
		complete_run();
	end
endmodule : lcd_frame_waveform_sleep_tb

// *** testbench/lcd_panel_model.sv ***
// Passive panel model: net DC and energy of one dark and one clear pixel
`timescale 1ns/1ps
module lcd_panel_model (
	// Clock and window restart
	input  wire logic             clk_i,
	input  wire logic             clr_i,
	// Panel lines
	input  wire logic [3:0][1:0]  com_i,
	input  wire logic [23:0][1:0] seg_i,
	// Figures summed since the last restart
	output int                    dc_dark_o,
	output int                    dc_clear_o,
	output int                    en_dark_o,
	output int                    en_clear_o
);
	int d0;
	int d1;

	// Pixels under test sit on the first common, segments 0 and 1
	assign d0 = int'(com_i[0]) - int'(seg_i[0]);
	assign d1 = int'(com_i[0]) - int'(seg_i[1]);

	// The glass integrates what it sees; a window of whole periods must net zero
	always @(posedge clk_i)
	begin
		dc_dark_o  <= clr_i ? 0 : dc_dark_o + d0;
		dc_clear_o <= clr_i ? 0 : dc_clear_o + d1;
		en_dark_o  <= clr_i ? 0 : en_dark_o + d0 * d0;
		en_clear_o <= clr_i ? 0 : en_clear_o + d1 * d1;
	end
endmodule : lcd_panel_model
